/* logic/ssic_params.svh */
// Constants for the stack, status and interrupt core
`ifndef SSIC_PARAMS_SVH
`define SSIC_PARAMS_SVH
`define SSIC_PC_W 10
`define SSIC_STACK_DEPTH 2
`define SSIC_ADDR_IND0 7'h00
`define SSIC_ADDR_PTR0 7'h01
`define SSIC_ADDR_IND1 7'h02
`define SSIC_ADDR_PTR1 7'h03
`define SSIC_ADDR_TPTR 7'h07
`define SSIC_ADDR_STAT 7'h0A
`define SSIC_ADDR_ICTL0 7'h0B
`define SSIC_ADDR_ICTL1 7'h1E
`define SSIC_RAM_LO 7'h40
`define SSIC_RAM_HI 7'h7F
`define SSIC_VEC_EXT 10'h004
`define SSIC_VEC_TMR 10'h008
`define SSIC_VEC_TB 10'h00C
`define SSIC_VEC_RTC 10'h010
`define SSIC_ST_C 0
`define SSIC_ST_HC 1
`define SSIC_ST_Z 2
`define SSIC_ST_OVF 3
`define SSIC_ST_PWRDN 4
`define SSIC_ST_WDTO 5
`define SSIC_IC_GIE 0
`define SSIC_IC_EEI 1
`define SSIC_IC_ETI 2
`define SSIC_IC_ETBI 3
`define SSIC_IC_EXTREQ 4
`define SSIC_IC_TMRREQ 5
`define SSIC_IC_TBREQ 6
`define SSIC_IC1_ERTI 0
`define SSIC_IC1_RTCREQ 4
`define SSIC_IC0_MASK 8'h7F
`define SSIC_IC1_MASK 8'h11
`define SSIC_ARITH_MASK 8'h0F
`define SSIC_ZERO8 8'h00
`define SSIC_LAST_PAGE 2'h3
`endif

/* logic/ssic_pkg.sv */
// Types for the stack, status and interrupt core
package ssic_pkg;
	typedef enum logic [1:0] {SSIC_RUN, SSIC_XFER} ssic_phase_t;
	// Flag results from the ALU for one operation
	typedef struct packed {
		logic upd_arith;
		logic upd_carry_only;
		logic carry;
		logic half_carry;
		logic zero;
		logic overflow;
	} ssic_alu_flags_t;
	// Sequencer control events
	typedef struct packed {
		logic boundary;
		logic call;
		logic ret;
		logic return_from_irq_instr;
		logic halt;
		logic wdt_clear;
		logic wdt_timeout;
	} ssic_seq_t;
endpackage

/* logic/ssic_core.sv */
// Stack, status flags, interrupts and indirect addressing of the core
`timescale 1ns/1ps
`include "ssic_params.svh"
module ssic_core
	import ssic_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire logic [9:0] pc,
	input wire ssic_seq_t seq,
	input wire ssic_alu_flags_t alu,
	input wire logic [6:0] mem_addr,
	input wire logic mem_rd,
	input wire logic mem_wr,
	input wire logic [7:0] mem_wdata,
	input wire logic indirect_src,
	input wire logic [7:0] ram_rdata,
	input wire logic tbl_last_page,
	input wire logic ext_int_n,
	input wire logic timer_ovf,
	input wire logic timebase_tick,
	input wire logic rtc_tick,
	output logic [6:0] ram_addr,
	output logic ram_rd,
	output logic ram_wr,
	output logic ram_disp_sel,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	output logic [9:0] table_addr,
	output logic [9:0] pc_load_value,
	output logic pc_load,
	output logic flush_fetch,
	output logic irq_ack,
	output logic wakeup,
	output logic stack_full,
	output logic [7:0] status_out
);
	// ------------------------------------------------------------
	// Decode helpers
	// ------------------------------------------------------------
	// Indirect port test, used for both the access and its target
	function automatic logic is_indirect(input logic [6:0] a);
		is_indirect = (a == `SSIC_ADDR_IND0) || (a == `SSIC_ADDR_IND1);
	endfunction

	// Window test shared by the read and write strobes
	function automatic logic in_ram_window(input logic [6:0] a);
		in_ram_window = (a >= `SSIC_RAM_LO) && (a <= `SSIC_RAM_HI);
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	// Stack slots and index are kept off the register map on purpose
	logic [9:0] stack_q [`SSIC_STACK_DEPTH];
	logic [1:0] stack_index_q;
	logic [6:0] memory_pointer_zero_q;
	logic [6:0] memory_pointer_one_q;
	logic [7:0] table_pointer_q;
	logic [7:0] status_flags_q;
	logic [7:0] ictl0_q;
	logic [7:0] ictl1_q;
	logic ext_pin_q;
	ssic_phase_t phase_q;
	logic [9:0] vec_d;
	logic take_irq;
	logic [3:0] pend;
	logic [6:0] eff_addr;
	logic ind_access;
	logic ind_self;
	logic wr_sfr;
	logic ext_fall;

	// ------------------------------------------------------------
	// Indirect addressing and data memory decode
	// ------------------------------------------------------------
	// Redirect ports 00H and 02H through the pointers
	always_comb begin
		ind_access = is_indirect(mem_addr);
		eff_addr = mem_addr;
		if (mem_addr == `SSIC_ADDR_IND0) begin
			eff_addr = memory_pointer_zero_q;
		end else if (mem_addr == `SSIC_ADDR_IND1) begin
			eff_addr = memory_pointer_one_q;
		end
		// Pointer aimed at a port itself: reads zero, writes dropped
		ind_self = ind_access && is_indirect(eff_addr);
	end

	// Only pointer one may steer into display memory
	assign ram_disp_sel = (mem_addr == `SSIC_ADDR_IND1);
	// General RAM window 40H..7FH; lower addresses are registers
	assign ram_addr = eff_addr;
	assign ram_rd = mem_rd && !ind_self && in_ram_window(eff_addr);
	assign ram_wr = mem_wr && !ind_self && in_ram_window(eff_addr);
	// Moves between the two ports are not supported; a source port refuses only the register write, not ram_wr
	assign wr_sfr = mem_wr && !ind_self && !(indirect_src && ind_access);

	// Register readback mux; stack is never mapped
	always_comb begin
		sfr_hit = 1'b1;
		sfr_rdata = `SSIC_ZERO8;
		if (ind_self) begin
			sfr_rdata = `SSIC_ZERO8;
		end else if (eff_addr == `SSIC_ADDR_PTR0) begin
			sfr_rdata = {1'b0, memory_pointer_zero_q};
		end else if (eff_addr == `SSIC_ADDR_PTR1) begin
			sfr_rdata = {1'b0, memory_pointer_one_q};
		end else if (eff_addr == `SSIC_ADDR_TPTR) begin
			sfr_rdata = table_pointer_q;
		end else if (eff_addr == `SSIC_ADDR_STAT) begin
			sfr_rdata = status_flags_q;
		end else if (eff_addr == `SSIC_ADDR_ICTL0) begin
			sfr_rdata = ictl0_q;
		end else if (eff_addr == `SSIC_ADDR_ICTL1) begin
			sfr_rdata = ictl1_q;
		end else begin
			sfr_hit = ind_access;
		end
	end

	// ------------------------------------------------------------
	// Pointer and table registers
	// ------------------------------------------------------------
	// Pointers are 7 bits; top data bit ignored
	always_ff @(posedge clock) begin
		if (rst) begin
			memory_pointer_zero_q <= 7'h00;
			memory_pointer_one_q <= 7'h00;
			table_pointer_q <= `SSIC_ZERO8;
		end else if (wr_sfr) begin
			if (eff_addr == `SSIC_ADDR_PTR0) begin
				memory_pointer_zero_q <= mem_wdata[6:0];
			end else if (eff_addr == `SSIC_ADDR_PTR1) begin
				memory_pointer_one_q <= mem_wdata[6:0];
			end else if (eff_addr == `SSIC_ADDR_TPTR) begin
				table_pointer_q <= mem_wdata;
			end
		end
	end

	// Table address: current page or forced last page
	always_ff @(posedge clock) begin
		if (rst) begin
			table_addr <= 10'h000;
		end else begin
			table_addr <= {tbl_last_page ? `SSIC_LAST_PAGE : pc[9:8], table_pointer_q};
		end
	end

	// ------------------------------------------------------------
	// Status register
	// ------------------------------------------------------------
	// ALU result wins over a software write in the same cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			status_flags_q <= `SSIC_ZERO8;
		end else begin
			if (wr_sfr && eff_addr == `SSIC_ADDR_STAT) begin
				status_flags_q[3:0] <= 4'(mem_wdata & `SSIC_ARITH_MASK);
			end
			if (alu.upd_arith) begin
				status_flags_q[`SSIC_ST_C] <= alu.carry;
				status_flags_q[`SSIC_ST_HC] <= alu.half_carry;
				status_flags_q[`SSIC_ST_Z] <= alu.zero;
				status_flags_q[`SSIC_ST_OVF] <= alu.overflow;
			end else if (alu.upd_carry_only) begin
				status_flags_q[`SSIC_ST_C] <= alu.carry;
			end
			// Power flags move only on these instructions and events
			if (seq.wdt_clear) begin
				status_flags_q[`SSIC_ST_PWRDN] <= 1'b0;
				status_flags_q[`SSIC_ST_WDTO] <= 1'b0;
			end else if (seq.halt) begin
				status_flags_q[`SSIC_ST_PWRDN] <= 1'b1;
				status_flags_q[`SSIC_ST_WDTO] <= 1'b0;
			end
			// Time-out comes last so it wins over a clear in the same cycle
			if (seq.wdt_timeout) begin
				status_flags_q[`SSIC_ST_WDTO] <= 1'b1;
			end
			status_flags_q[7:6] <= 2'h0;
		end
	end
	assign status_out = status_flags_q;

	// ------------------------------------------------------------
	// Interrupt requests and arbitration
	// ------------------------------------------------------------
	// Pin sampled once; falling edge compares the registered copy with the live pin
	always_ff @(posedge clock) begin
		if (rst) begin
			ext_pin_q <= 1'b1;
		end else begin
			ext_pin_q <= ext_int_n;
		end
	end
	assign ext_fall = ext_pin_q && !ext_int_n;

	// Pending and enabled, in priority order
	assign pend[0] = ictl0_q[`SSIC_IC_EXTREQ] && ictl0_q[`SSIC_IC_EEI];
	assign pend[1] = ictl0_q[`SSIC_IC_TMRREQ] && ictl0_q[`SSIC_IC_ETI];
	assign pend[2] = ictl0_q[`SSIC_IC_TBREQ] && ictl0_q[`SSIC_IC_ETBI];
	assign pend[3] = ictl1_q[`SSIC_IC1_RTCREQ] && ictl1_q[`SSIC_IC1_ERTI];
	assign stack_full = (stack_index_q == 2'(`SSIC_STACK_DEPTH));
	// Full stack holds the acknowledge, never the flag
	assign take_irq = seq.boundary && (phase_q == SSIC_RUN) && ictl0_q[`SSIC_IC_GIE] && (|pend)
		&& !stack_full;
	// Acknowledge leaves combinationally so the sequencer can hold its fetch
	assign irq_ack = take_irq;
	// No enable needed: any latched flag ends a halt
	assign wakeup = ictl0_q[`SSIC_IC_EXTREQ] | ictl0_q[`SSIC_IC_TMRREQ] | ictl0_q[`SSIC_IC_TBREQ]
		| ictl1_q[`SSIC_IC1_RTCREQ];

	// Fixed priority vector select
	always_comb begin
		if (pend[0]) begin
			vec_d = `SSIC_VEC_EXT;
		end else if (pend[1]) begin
			vec_d = `SSIC_VEC_TMR;
		end else if (pend[2]) begin
			vec_d = `SSIC_VEC_TB;
		end else begin
			vec_d = `SSIC_VEC_RTC;
		end
	end

	// Control registers; hardware set wins over software clear
	always_ff @(posedge clock) begin
		if (rst) begin
			ictl0_q <= `SSIC_ZERO8;
			ictl1_q <= `SSIC_ZERO8;
		end else begin
			if (wr_sfr && eff_addr == `SSIC_ADDR_ICTL0) begin
				ictl0_q <= mem_wdata & `SSIC_IC0_MASK;
			end
			if (wr_sfr && eff_addr == `SSIC_ADDR_ICTL1) begin
				ictl1_q <= mem_wdata & `SSIC_IC1_MASK;
			end
			if (seq.return_from_irq_instr) begin
				ictl0_q[`SSIC_IC_GIE] <= 1'b1;
			end
			if (take_irq) begin
				ictl0_q[`SSIC_IC_GIE] <= 1'b0;
				if (pend[0]) begin
					ictl0_q[`SSIC_IC_EXTREQ] <= 1'b0;
				end else if (pend[1]) begin
					ictl0_q[`SSIC_IC_TMRREQ] <= 1'b0;
				end else if (pend[2]) begin
					ictl0_q[`SSIC_IC_TBREQ] <= 1'b0;
				end else begin
					ictl1_q[`SSIC_IC1_RTCREQ] <= 1'b0;
				end
			end
			// Flags latch even while blocked
			if (ext_fall) begin
				ictl0_q[`SSIC_IC_EXTREQ] <= 1'b1;
			end
			if (timer_ovf) begin
				ictl0_q[`SSIC_IC_TMRREQ] <= 1'b1;
			end
			if (timebase_tick) begin
				ictl0_q[`SSIC_IC_TBREQ] <= 1'b1;
			end
			if (rtc_tick) begin
				ictl1_q[`SSIC_IC1_RTCREQ] <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Return stack and control transfer
	// ------------------------------------------------------------
	// Push on call or acknowledge; pop on either return. No status saved.
	always_ff @(posedge clock) begin
		if (rst) begin
			stack_index_q <= 2'h0;
			stack_q[0] <= 10'h000;
			stack_q[1] <= 10'h000;
		end else if (seq.call || take_irq) begin
			if (stack_full) begin
				stack_q[0] <= stack_q[1];
				stack_q[1] <= pc;
			end else begin
				stack_q[stack_index_q[0]] <= pc;
				stack_index_q <= stack_index_q + 2'h1;
			end
		end else if ((seq.ret || seq.return_from_irq_instr) && stack_index_q != 2'h0) begin
			// An empty stack ignores the return rather than wrapping the index
			stack_index_q <= stack_index_q - 2'h1;
		end
	end

	// Transfer phase discards the already fetched word
	always_ff @(posedge clock) begin
		if (rst) begin
			phase_q <= SSIC_RUN;
			pc_load <= 1'b0;
			pc_load_value <= 10'h000;
			flush_fetch <= 1'b0;
		end else begin
			pc_load <= 1'b0;
			flush_fetch <= 1'b0;
			phase_q <= SSIC_RUN;
			if (take_irq) begin
				phase_q <= SSIC_XFER;
				pc_load <= 1'b1;
				flush_fetch <= 1'b1;
				pc_load_value <= vec_d;
			end else if ((seq.ret || seq.return_from_irq_instr) && stack_index_q != 2'h0) begin
				pc_load <= 1'b1;
				flush_fetch <= 1'b1;
				// Popped word sits one slot below the index
				pc_load_value <= stack_q[stack_index_q[1]];
			end
		end
	end
endmodule

/* test/ssic_seq_model.sv */
// Sequencer stand-in: program counter and instruction boundaries
`timescale 1ns/1ps
module ssic_seq_model #(
	parameter logic [9:0] PC_START = 10'h180
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic pc_load,
	input wire logic [9:0] pc_load_value,
	input wire logic flush_fetch,
	output logic [9:0] pc,
	output logic boundary
);
	// -------------------------------
	// Fetch counter
	// -------------------------------
	// Steps every cycle, takes the vector or popped address on a load
	always_ff @(posedge clock) begin
		if (rst) begin
			pc <= PC_START;
		end else if (pc_load) begin
			pc <= pc_load_value;
		end else begin
			pc <= pc + 10'h001;
		end
	end
	// No boundary in the dummy cycle that drops the fetched word
	assign boundary = !flush_fetch && !rst;
endmodule

/* test/ssic_core_asserts.sv */
// Checker for the stack, status and interrupt core
`timescale 1ns/1ps
module ssic_core_asserts
	import ssic_pkg::*;
(
	input wire logic clock,
	input wire logic rst,
	input wire ssic_seq_t seq,
	input wire logic tbl_last_page,
	input wire logic ext_int_n,
	input wire logic [6:0] ram_addr,
	input wire logic ram_rd,
	input wire logic ram_wr,
	input wire logic [9:0] table_addr,
	input wire logic pc_load,
	input wire logic flush_fetch,
	input wire logic irq_ack,
	input wire logic wakeup,
	input wire logic stack_full,
	input wire logic [7:0] status_out
);
	// -------------------------------
	// Properties
	// -------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// One load-and-flush cycle, then the line is quiet again
	sequence s_xfer;
		pc_load && flush_fetch ##1 !pc_load && !flush_fetch;
	endsequence
	a_ack_transfer: assert property (irq_ack |=> s_xfer)
		else $error("no two-cycle transfer after acknowledge");
	a_ack_room: assert property (irq_ack |-> !stack_full && seq.boundary)
		else $error("acknowledge with full stack or off boundary");
	a_ack_single: assert property (irq_ack |=> !irq_ack)
		else $error("acknowledge in two adjacent cycles");
	a_status_top: assert property (status_out[7:6] == 2'h0)
		else $error("unused status bits not zero");
	a_halt_power: assert property (seq.halt && !seq.wdt_clear |=> status_out[4:4] == 1'b1)
		else $error("halt did not set power-down flag");
	a_dog_timeout: assert property (seq.wdt_timeout |=> status_out[5:5] == 1'b1)
		else $error("time-out did not set its flag");
	a_table_page: assert property (tbl_last_page |=> table_addr[9:8] == 2'h3)
		else $error("last page table address wrong");
	a_ram_window: assert property (ram_rd || ram_wr |-> ram_addr >= 7'h40)
		else $error("memory strobe outside general memory");
	a_ext_edge: assert property ($fell(ext_int_n) |-> ##[1:2] wakeup)
		else $error("pin edge did not raise a request");
endmodule
bind ssic_core ssic_core_asserts ssic_core_asserts_inst (.clock(clock), .rst(rst), .seq(seq),
	.tbl_last_page(tbl_last_page), .ext_int_n(ext_int_n), .ram_addr(ram_addr), .ram_rd(ram_rd),
	.ram_wr(ram_wr), .table_addr(table_addr), .pc_load(pc_load), .flush_fetch(flush_fetch),
	.irq_ack(irq_ack), .wakeup(wakeup), .stack_full(stack_full), .status_out(status_out));

/* test/tb_stack_status_interrupt_core.sv */
// Self-checking bench for the stack, status and interrupt core
`timescale 1ns/1ps
module tb_stack_status_interrupt_core
	import ssic_pkg::*;
;
	localparam logic [9:0] CALL = 10'h100, EV_RETURN = 10'h080, EV_RETURN_IRQ = 10'h040, HALT = 10'h020;
	localparam logic [9:0] WCLR = 10'h010, WTO = 10'h008, EXT = 10'h200;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [9:0] ev = 10'h000;
	logic [6:0] mem_addr = 7'h00;
	logic mem_rd = 1'b0;
	logic mem_wr = 1'b0;
	logic [7:0] mem_wdata = 8'h00;
	logic tbl_last_page = 1'b0;
	ssic_alu_flags_t alu = '0;
	logic [9:0] pc, pc_load_value, table_addr, cap, p1, p2, p3;
	logic [6:0] ram_addr;
	logic [7:0] sfr_rdata, status_out;
	logic ram_rd, ram_wr, ram_disp_sel, pc_load, flush_fetch, irq_ack, wakeup, stack_full, bnd, sfr_hit;
	logic [9:0] vec [4] = '{10'h004, 10'h008, 10'h00C, 10'h010};
	int checks = 0;
	int fails = 0;
	int cyc = 0;

	always #5 clock = ~clock;

	ssic_core ssic_core_inst (.clock(clock), .rst(rst), .pc(pc), .seq(ssic_seq_t'({bnd, ev[8:3]})),
		.alu(alu), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
		.indirect_src(1'b0), .ram_rdata(8'h00), .tbl_last_page(tbl_last_page), .ext_int_n(!ev[9]),
		.timer_ovf(ev[0]), .timebase_tick(ev[1]), .rtc_tick(ev[2]), .ram_addr(ram_addr),
		.ram_rd(ram_rd), .ram_wr(ram_wr), .ram_disp_sel(ram_disp_sel), .sfr_rdata(sfr_rdata),
		.sfr_hit(sfr_hit), .table_addr(table_addr), .pc_load_value(pc_load_value), .pc_load(pc_load),
		.flush_fetch(flush_fetch), .irq_ack(irq_ack), .wakeup(wakeup), .stack_full(stack_full),
		.status_out(status_out));
	ssic_seq_model ssic_seq_model_inst (.clock(clock), .rst(rst), .pc_load(pc_load),
		.pc_load_value(pc_load_value), .flush_fetch(flush_fetch), .pc(pc), .boundary(bnd));

	// -------------------------------
	// Access and compare tasks
	// -------------------------------
	task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clock);
		mem_addr = a;
		mem_wdata = d;
		mem_wr = 1'b1;
		@(negedge clock);
		mem_wr = 1'b0;
	endtask
	// Read data is combinational, so it is looked at inside the strobe cycle
	task automatic rd(input logic [6:0] a, input logic [7:0] e, input logic ram);
		@(negedge clock);
		mem_addr = a;
		mem_rd = 1'b1;
		#1;
		if (ram) chk({2'h0, ram_rd, ram_disp_sel, ram_addr}, {3'h1, e}, "indirect");
		else chk({3'h0, sfr_rdata}, {3'h0, e}, "register");
		@(negedge clock);
		mem_rd = 1'b0;
	endtask
	// One-cycle event; the counter value seen in that cycle is kept
	task automatic pulse(input logic [9:0] m);
		@(negedge clock);
		ev = m;
		cap = pc;
		@(negedge clock);
		ev = 10'h000;
	endtask
	task automatic pop(input logic [9:0] m, input logic [9:0] v);
		pulse(m);
		#1 chk({pc_load, pc_load_value}, {1'b1, v}, "return address");
	endtask
	// Bounded wait, then the vector must follow one cycle after the acknowledge
	task automatic wait_ack(input logic [9:0] v);
		int n;
		n = 0;
		#1;
		while (irq_ack !== 1'b1 && n < 8) begin
			@(negedge clock);
			#1;
			n++;
		end
		cap = pc;
		@(negedge clock);
		chk({pc_load, pc_load_value}, {1'b1, v}, "vector");
	endtask
	task automatic summarize();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Hang guard, far above the hundred-odd cycles the tests need
	always @(posedge clock) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			summarize();
		end
	end

	// -------------------------------
	// Test sequence
	// -------------------------------
	initial begin
		repeat (20) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		#1 chk({10'h000, stack_full}, 11'h000, "stack after reset");
		rd(7'h0A, 8'h00, 1'b0);
		wr(7'h0A, 8'hFF);
		rd(7'h0A, 8'h0F, 1'b0);
		pulse(WTO);
		rd(7'h0A, 8'h2F, 1'b0);
		pulse(HALT);
		rd(7'h0A, 8'h1F, 1'b0);
		pulse(WCLR);
		rd(7'h0A, 8'h0F, 1'b0);
		@(negedge clock);
		alu = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
		@(negedge clock);
		alu = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
		@(negedge clock);
		alu = '0;
		rd(7'h0A, 8'h04, 1'b0);
		$display("status test done");
		wr(7'h01, 8'h7F);
		wr(7'h03, 8'h40);
		rd(7'h00, 8'h7F, 1'b1);
		rd(7'h02, 8'hC0, 1'b1);
		// Direct memory read, then a write steered through pointer zero
		@(negedge clock);
		mem_addr = 7'h41;
		mem_rd = 1'b1;
		#1 chk({2'h0, sfr_hit, ram_rd, ram_addr}, {4'h1, 7'h41}, "direct memory");
		@(negedge clock);
		mem_rd = 1'b0;
		mem_addr = 7'h00;
		mem_wr = 1'b1;
		#1 chk({3'h0, ram_wr, ram_addr}, {4'h1, 7'h7F}, "indirect write");
		@(negedge clock);
		mem_wr = 1'b0;
		wr(7'h01, 8'h02);
		rd(7'h00, 8'h00, 1'b0);
		wr(7'h07, 8'h5A);
		tbl_last_page = 1'b1;
		@(negedge clock);
		chk({1'b0, table_addr}, 11'h35A, "last page");
		tbl_last_page = 1'b0;
		cap = pc;
		@(negedge clock);
		chk({1'b0, table_addr}, {1'b0, cap[9:8], 8'h5A}, "current page");
		$display("addressing test done");
		wr(7'h0B, 8'h05);
		pulse(10'h001);
		wait_ack(10'h008);
		rd(7'h0B, 8'h04, 1'b0);
		pulse(CALL);
		p1 = cap;
		#1 chk({10'h000, stack_full}, 11'h001, "stack full");
		pulse(CALL);
		p2 = cap;
		wr(7'h0B, 8'h05);
		pulse(10'h001);
		#1 chk({10'h000, irq_ack}, 11'h000, "ack while full");
		rd(7'h0B, 8'h25, 1'b0);
		pop(EV_RETURN_IRQ, p2);
		wait_ack(10'h008);
		p3 = cap;
		pop(EV_RETURN, p3);
		pop(EV_RETURN, p1);
		rd(7'h0B, 8'h04, 1'b0);
		pulse(CALL);
		pop(EV_RETURN_IRQ, cap);
		rd(7'h0B, 8'h05, 1'b0);
		$display("stack test done");
		wr(7'h0B, 8'h0E);
		wr(7'h1E, 8'h01);
		pulse(EXT | 10'h007);
		#1 chk({10'h000, wakeup}, 11'h001, "wake request");
		rd(7'h0B, 8'h7E, 1'b0);
		rd(7'h1E, 8'h11, 1'b0);
		wr(7'h0B, 8'h7F);
		for (int i = 0; i < 4; i++) begin
			wait_ack(vec[i]);
			pulse(EV_RETURN_IRQ);
		end
		rd(7'h0B, 8'h0F, 1'b0);
		rd(7'h1E, 8'h01, 1'b0);
		$display("priority test done");
		summarize();
	end
endmodule
